// File: src/ucs_pkg.sv
// constants for the uart control and status register block
package ucs_pkg;
   // ----------------------------------------------------------------
   // register byte offsets on the apb
   // ----------------------------------------------------------------
   localparam logic [7:0] UCS_OFF_ISR = 8'h00;
   localparam logic [7:0] UCS_OFF_FCR = 8'h04;
   localparam logic [7:0] UCS_OFF_LCR = 8'h08;
   localparam logic [7:0] UCS_OFF_MCR = 8'h0c;
   localparam logic [7:0] UCS_OFF_EFE = 8'h10;
   localparam logic [7:0] UCS_OFF_FCTL = 8'h14;
   localparam logic [7:0] UCS_OFF_TRG = 8'h18;
   localparam logic [7:0] UCS_OFF_GIE = 8'h1c;
   localparam logic [7:0] UCS_OFF_TRIG_STAT = 8'h20;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int UCS_FCR_EN = 0;
   localparam int UCS_FCR_RXCLR = 1;
   localparam int UCS_FCR_TXCLR = 2;
   localparam int UCS_FCR_WAKE = 3;
   localparam int UCS_FCR_TXTRIG_LO = 4;
   localparam int UCS_FCR_RXTRIG_LO = 6;
   localparam int UCS_LCR_STOP = 2;
   localparam int UCS_LCR_PAR_EN = 3;
   localparam int UCS_LCR_PAR_EVEN = 4;
   localparam int UCS_LCR_PAR_FORCE = 5;
   localparam int UCS_LCR_BREAK = 6;
   localparam int UCS_LCR_DIVSEL = 7;
   localparam int UCS_MCR_DTR = 0;
   localparam int UCS_MCR_RTS = 1;
   localparam int UCS_MCR_MODEM_SEL = 2;
   localparam int UCS_MCR_INT_EN = 3;
   localparam int UCS_MCR_LOOP = 4;
   localparam int UCS_EFE_ENH = 4;
   localparam int UCS_FCTL_TBL_LO = 4;
   localparam int UCS_FCTL_TRG_TX = 7;

   // ----------------------------------------------------------------
   // reset values and interrupt codes
   // ----------------------------------------------------------------
   localparam logic [7:0] UCS_LCR_RST = 8'h00;
   localparam logic [7:0] UCS_MCR_RST = 8'h00;
   localparam logic [7:0] UCS_EFE_RST = 8'h00;
   localparam logic [7:0] UCS_FCTL_RST = 8'h00;
   localparam logic [7:0] UCS_GIE_RST = 8'h00;
   localparam logic [7:0] UCS_TRG_RST = 8'h01;
   localparam logic [1:0] UCS_CODE_RST = 2'h0;
   localparam logic [2:0] UCS_SRC_LINE = 3'h3;
   localparam logic [2:0] UCS_SRC_RXTO = 3'h6;
   localparam logic [2:0] UCS_SRC_RXRDY = 3'h2;
   localparam logic [2:0] UCS_SRC_TXRDY = 3'h1;
   localparam logic [2:0] UCS_SRC_OTHER = 3'h0;

   // trigger table selector codes
   typedef enum logic [1:0] {
      UCS_TBL_A = 2'h0,
      UCS_TBL_B = 2'h1,
      UCS_TBL_C = 2'h2,
      UCS_TBL_D = 2'h3
   } ucs_table_t;
endpackage : ucs_pkg

// File: src/ucs_regs.sv
// uart control and status registers behind an apb slave
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1: status bits 3..1 encode top pending source
// RULE2: bits 4,5 flag char match, cts/rts rise
// RULE3: bit7 fifo enable, bit6 xor gpio interrupt
// RULE4: other fifo bits need enable in write
// RULE5: fifo clear bits pulse once, self-clear
// RULE6: wake-up interrupt gated by fifo bit3
// RULE7: tx interrupt when count below trigger
// RULE8: rx interrupt when count reaches trigger
// RULE9: one trigger table shared by both directions
// RULE10: table A rx 1,4,8,14, tx 1
// RULE11: tables B and C fixed level sets
// RULE12: table D from programmable trigger register
// RULE13: line bits 1:0 give 5..8 data bits
// RULE14: stop select gives 1, 1.5 or 2
// RULE15: parity enable and odd/even type
// RULE16: forced parity mark or space
// RULE17: break holds transmit output low
// RULE18: line bit7 selects divisor latches
// RULE19: dtr/rts active low from modem bits
// RULE20: modem bit2 selects gpio or modem pins
// RULE21: modem bit3 interrupt drive, loop output two
// RULE22: modem bit4 enables internal loopback
// RULE23: status bit0 low while anything pending; a gpio interrupt alone leaves it high
// RULE24: all fields reset to defaults
module ucs_regs
   import ucs_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic line_status_pend,
   input wire logic rx_timeout_pend,
   input wire logic modem_status_pend,
   input wire logic [CNT_W-1:0] rx_count,
   input wire logic [CNT_W-1:0] tx_count,
   input wire logic char_match_evt,
   input wire logic cts_rise_evt,
   input wire logic rts_rise_evt,
   input wire logic modem_status_read,
   input wire logic wakeup_evt,
   input wire logic gpio_irq_level,
   input wire logic bus_mode_alt_pin,
   input wire logic tx_serial_raw,
   output logic tx_serial_out,
   output logic fifo_enable,
   output logic rx_fifo_clear,
   output logic tx_fifo_clear,
   output logic [7:0] rx_trigger,
   output logic [7:0] tx_trigger,
   output logic [3:0] char_bits,
   output logic stop_long,
   output logic parity_enable,
   output logic parity_even,
   output logic parity_forced,
   output logic divisor_select,
   output logic dtr_n,
   output logic rts_n,
   output logic gpio_modem_select,
   output logic loopback_enable,
   output logic loop_output_one_n,
   output logic loop_output_two_n,
   output logic irq_out,
   output logic irq_oe
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   // levels up to 60 must compare against the fifo count
   if (CNT_W < 6 || CNT_W > 8) begin : g_bad_width
      $error("ucs_regs: CNT_W must be 6 to 8");
   end

   // ----------------------------------------------------------------
   // trigger table decode
   // ----------------------------------------------------------------
   // shared lookup, used for both directions
   function automatic logic [7:0] trig_lookup(
      input logic [1:0] tbl,
      input logic [1:0] code,
      input logic is_tx,
      input logic [7:0] prog
   );
      logic [7:0] lvl;
      lvl = 8'h01;
      unique case (tbl)
         UCS_TBL_A: begin
            if (!is_tx) begin
               unique case (code)
                  2'h0: lvl = 8'h01;
                  2'h1: lvl = 8'h04;
                  2'h2: lvl = 8'h08;
                  2'h3: lvl = 8'h0e;
               endcase
            end
         end
         UCS_TBL_B: begin
            unique case (code)
               2'h0: lvl = is_tx ? 8'h10 : 8'h08;
               2'h1: lvl = is_tx ? 8'h08 : 8'h10;
               2'h2: lvl = 8'h18;
               2'h3: lvl = is_tx ? 8'h1e : 8'h1c;
            endcase
         end
         UCS_TBL_C: begin
            unique case (code)
               2'h0: lvl = 8'h08;
               2'h1: lvl = 8'h10;
               2'h2: lvl = is_tx ? 8'h20 : 8'h38;
               2'h3: lvl = is_tx ? 8'h38 : 8'h3c;
            endcase
         end
         UCS_TBL_D: lvl = prog;
      endcase
      return lvl;
   endfunction : trig_lookup

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic setup_ph;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign mapped = (paddr == UCS_OFF_ISR) || (paddr == UCS_OFF_FCR) ||
      (paddr == UCS_OFF_LCR) || (paddr == UCS_OFF_MCR) ||
      (paddr == UCS_OFF_EFE) || (paddr == UCS_OFF_FCTL) ||
      (paddr == UCS_OFF_TRG) || (paddr == UCS_OFF_GIE) ||
      (paddr == UCS_OFF_TRIG_STAT);
   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   logic wr_fcr;
   logic wr_trg;
   logic rd_isr;
   assign wr_fcr = wr_acc && paddr == UCS_OFF_FCR;
   assign wr_trg = wr_acc && paddr == UCS_OFF_TRG;
   assign rd_isr = setup_ph && !pwrite && paddr == UCS_OFF_ISR;

   // ----------------------------------------------------------------
   // bus mode strap synchroniser
   // ----------------------------------------------------------------
   logic mode_meta_reg;
   logic mode_alt_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_meta_reg <= 1'b0;
         mode_alt_reg <= 1'b0;
      end else begin
         mode_meta_reg <= bus_mode_alt_pin;
         mode_alt_reg <= mode_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // line, modem and feature registers
   // ----------------------------------------------------------------
   logic [7:0] lcr_reg;
   logic [7:0] mcr_reg;
   logic [7:0] efe_reg;
   logic [7:0] fctl_reg;
   logic [7:0] gie_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lcr_reg <= UCS_LCR_RST; // RULE24
         mcr_reg <= UCS_MCR_RST;
         efe_reg <= UCS_EFE_RST;
         fctl_reg <= UCS_FCTL_RST;
         gie_reg <= UCS_GIE_RST;
      end else if (wr_acc) begin
         if (paddr == UCS_OFF_LCR) lcr_reg <= pwdata[7:0];
         if (paddr == UCS_OFF_MCR) mcr_reg <= pwdata[7:0];
         if (paddr == UCS_OFF_EFE) efe_reg <= pwdata[7:0];
         // one table field serves rx and tx, so last write wins
         if (paddr == UCS_OFF_FCTL) fctl_reg <= pwdata[7:0]; // RULE9
         if (paddr == UCS_OFF_GIE) gie_reg <= pwdata[7:0];
      end
   end

   logic enh_on;
   assign enh_on = efe_reg[UCS_EFE_ENH];

   // ----------------------------------------------------------------
   // fifo setup (write only)
   // ----------------------------------------------------------------
   logic fifo_en_reg;
   logic [1:0] rx_code_reg;
   logic [1:0] tx_code_reg;
   logic wake_en_reg;
   logic rx_clr_reg;
   logic tx_clr_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fifo_en_reg <= 1'b0; // RULE24
         rx_code_reg <= UCS_CODE_RST;
         tx_code_reg <= UCS_CODE_RST;
         wake_en_reg <= 1'b0;
      end else if (wr_fcr) begin
         fifo_en_reg <= pwdata[UCS_FCR_EN]; // RULE4
         if (pwdata[UCS_FCR_EN]) begin // RULE4
            rx_code_reg <= pwdata[UCS_FCR_RXTRIG_LO +: 2];
            if (enh_on) begin
               tx_code_reg <= pwdata[UCS_FCR_TXTRIG_LO +: 2];
               wake_en_reg <= pwdata[UCS_FCR_WAKE]; // RULE6
            end
         end
      end
   end

   // clear bits act for one cycle and then read back as zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_clr_reg <= 1'b0;
         tx_clr_reg <= 1'b0;
      end else begin
         rx_clr_reg <= wr_fcr && pwdata[UCS_FCR_EN] &&
            pwdata[UCS_FCR_RXCLR]; // RULE5
         tx_clr_reg <= wr_fcr && pwdata[UCS_FCR_EN] &&
            pwdata[UCS_FCR_TXCLR]; // RULE5
      end
   end

   // ----------------------------------------------------------------
   // programmable trigger levels
   // ----------------------------------------------------------------
   logic [7:0] rx_prog_reg;
   logic [7:0] tx_prog_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_prog_reg <= UCS_TRG_RST;
         tx_prog_reg <= UCS_TRG_RST;
      end else if (wr_trg) begin
         if (fctl_reg[UCS_FCTL_TRG_TX]) tx_prog_reg <= pwdata[7:0]; // RULE12
         else rx_prog_reg <= pwdata[7:0]; // RULE12
      end
   end

   logic [1:0] tbl;
   logic [7:0] rx_trig;
   logic [7:0] tx_trig;
   assign tbl = fctl_reg[UCS_FCTL_TBL_LO +: 2];
   // RULE10 RULE11 RULE12
   assign rx_trig = trig_lookup(tbl, rx_code_reg, 1'b0, rx_prog_reg);
   assign tx_trig = trig_lookup(tbl, tx_code_reg, 1'b1, tx_prog_reg);

   // ----------------------------------------------------------------
   // sticky event flags
   // ----------------------------------------------------------------
   // a new event in the clearing cycle is kept: set wins
   logic match_flag_reg;
   logic flow_flag_reg;
   logic wake_flag_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         match_flag_reg <= 1'b0;
         flow_flag_reg <= 1'b0;
         wake_flag_reg <= 1'b0;
      end else begin
         if (enh_on && char_match_evt) match_flag_reg <= 1'b1; // RULE2
         else if (rd_isr) match_flag_reg <= 1'b0;
         if (enh_on && (cts_rise_evt || rts_rise_evt))
            flow_flag_reg <= 1'b1; // RULE2
         else if (modem_status_read) flow_flag_reg <= 1'b0;
         if (enh_on && wake_en_reg && wakeup_evt)
            wake_flag_reg <= 1'b1; // RULE6
         else if (rd_isr) wake_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // interrupt source encoding
   // ----------------------------------------------------------------
   logic rx_rdy;
   logic tx_rdy;
   logic gpio_pend;
   logic any_pend;
   logic [7:0] isr_val;
   // fifo levels only count in fifo mode; else a single holding slot
   assign rx_rdy = fifo_en_reg ? (8'(rx_count) >= rx_trig) // RULE8
                               : (rx_count != '0);
   assign tx_rdy = fifo_en_reg ? (8'(tx_count) < tx_trig) // RULE7
                               : (tx_count == '0);
   assign gpio_pend = gpio_irq_level && (gie_reg != 8'h00);
   assign any_pend = line_status_pend || rx_timeout_pend || rx_rdy ||
      tx_rdy || modem_status_pend || match_flag_reg || flow_flag_reg ||
      wake_flag_reg;

   always_comb begin
      isr_val = 8'h00;
      isr_val[7] = fifo_en_reg; // RULE3
      isr_val[6] = fifo_en_reg ^ gpio_pend; // RULE3
      isr_val[0] = !any_pend; // RULE23
      if (line_status_pend) isr_val[3:1] = UCS_SRC_LINE; // RULE1
      else if (rx_timeout_pend) isr_val[3:1] = UCS_SRC_RXTO;
      else if (rx_rdy) isr_val[3:1] = UCS_SRC_RXRDY;
      else if (tx_rdy) isr_val[3:1] = UCS_SRC_TXRDY;
      else if (modem_status_pend) isr_val[3:1] = UCS_SRC_OTHER;
      else if (match_flag_reg) isr_val[4] = 1'b1; // RULE2
      else if (flow_flag_reg) isr_val[5] = 1'b1; // RULE2
   end

   // ----------------------------------------------------------------
   // read data, captured in the setup cycle
   // ----------------------------------------------------------------
   logic [31:0] prdata_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_reg <= 32'h0000_0000;
         unique case (paddr)
            UCS_OFF_ISR: prdata_reg[7:0] <= isr_val;
            UCS_OFF_LCR: prdata_reg[7:0] <= lcr_reg;
            UCS_OFF_MCR: prdata_reg[7:0] <= mcr_reg;
            UCS_OFF_EFE: prdata_reg[7:0] <= efe_reg;
            UCS_OFF_FCTL: prdata_reg[7:0] <= fctl_reg;
            UCS_OFF_GIE: prdata_reg[7:0] <= gie_reg;
            UCS_OFF_TRIG_STAT: prdata_reg[15:0] <= {tx_trig, rx_trig};
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end
   assign prdata = prdata_reg;

   // ----------------------------------------------------------------
   // serial output with break
   // ----------------------------------------------------------------
   logic tx_ser_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) tx_ser_reg <= 1'b1;
      else tx_ser_reg <= tx_serial_raw && !lcr_reg[UCS_LCR_BREAK]; // RULE17
   end
   assign tx_serial_out = tx_ser_reg;

   // ----------------------------------------------------------------
   // control outputs
   // ----------------------------------------------------------------
   assign fifo_enable = fifo_en_reg;
   assign rx_fifo_clear = rx_clr_reg;
   assign tx_fifo_clear = tx_clr_reg;
   assign rx_trigger = rx_trig;
   assign tx_trigger = tx_trig;
   // 5 + code gives 5..8 data bits
   assign char_bits = 4'h5 + {2'h0, lcr_reg[1:0]}; // RULE13
   assign stop_long = lcr_reg[UCS_LCR_STOP]; // RULE14
   assign parity_enable = lcr_reg[UCS_LCR_PAR_EN]; // RULE15
   assign parity_even = lcr_reg[UCS_LCR_PAR_EVEN]; // RULE15
   assign parity_forced = lcr_reg[UCS_LCR_PAR_EN] &&
      lcr_reg[UCS_LCR_PAR_FORCE]; // RULE16
   assign divisor_select = lcr_reg[UCS_LCR_DIVSEL]; // RULE18
   // modem pins are quiet while looped back
   assign dtr_n = !mcr_reg[UCS_MCR_DTR] || loopback_enable; // RULE19
   assign rts_n = !mcr_reg[UCS_MCR_RTS] || loopback_enable; // RULE19
   assign gpio_modem_select = mcr_reg[UCS_MCR_MODEM_SEL]; // RULE20
   assign loopback_enable = mcr_reg[UCS_MCR_LOOP]; // RULE22
   assign loop_output_one_n = !(loopback_enable &&
      mcr_reg[UCS_MCR_MODEM_SEL]); // RULE20
   assign loop_output_two_n = !(loopback_enable &&
      mcr_reg[UCS_MCR_INT_EN]); // RULE21
   assign irq_out = any_pend || gpio_pend;
   // alternate bus mode drives always; others obey the enable bit
   assign irq_oe = mode_alt_reg || mcr_reg[UCS_MCR_INT_EN]; // RULE21

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_rxclr_write;
      wr_fcr && pwdata[UCS_FCR_EN] && pwdata[UCS_FCR_RXCLR];
   endsequence
   sequence s_clear_pulse;
      rx_fifo_clear ##1 !rx_fifo_clear;
   endsequence
   property p_rx_clear;
      s_rxclr_write |=> s_clear_pulse;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("rx clear"); // RULE5

   property p_fcr_ignored;
      wr_fcr && !pwdata[UCS_FCR_EN] |=> !fifo_enable && $stable(rx_code_reg)
         && !rx_fifo_clear && !tx_fifo_clear;
   endproperty
   a_fcr_ignored: assert property (p_fcr_ignored)
      else $error("fcr write obeyed"); // RULE4

   property p_break;
      lcr_reg[UCS_LCR_BREAK] |=> !tx_serial_out;
   endproperty
   a_break: assert property (p_break) else $error("break not low"); // RULE17

   property p_isr_fifo_bit;
      setup_ph && !pwrite && paddr == UCS_OFF_ISR |=>
         prdata[7] == $past(fifo_en_reg) &&
         prdata[6] == ($past(fifo_en_reg) ^ $past(gpio_pend));
   endproperty
   a_isr_fifo_bit: assert property (p_isr_fifo_bit)
      else $error("isr fifo bits"); // RULE3

   property p_isr_line;
      setup_ph && !pwrite && paddr == UCS_OFF_ISR && line_status_pend |=>
         prdata[3:0] == 4'h6;
   endproperty
   a_isr_line: assert property (p_isr_line)
      else $error("isr line code"); // RULE1

   property p_isr_idle;
      setup_ph && !pwrite && paddr == UCS_OFF_ISR && !irq_out |=>
         prdata[5:0] == 6'h01;
   endproperty
   a_isr_idle: assert property (p_isr_idle) else $error("isr idle"); // RULE23

   property p_dtr;
      wr_acc && paddr == UCS_OFF_MCR && !pwdata[UCS_MCR_LOOP] |=>
         dtr_n == !$past(pwdata[UCS_MCR_DTR]);
   endproperty
   a_dtr: assert property (p_dtr) else $error("dtr level"); // RULE19

   property p_trg_rx;
      wr_trg && !fctl_reg[UCS_FCTL_TRG_TX] |=>
         rx_prog_reg == $past(pwdata[7:0]) && $stable(tx_prog_reg);
   endproperty
   a_trg_rx: assert property (p_trg_rx) else $error("trg route"); // RULE12

   property p_loop_two;
      wr_acc && paddr == UCS_OFF_MCR && pwdata[UCS_MCR_LOOP] &&
         pwdata[UCS_MCR_INT_EN] |=> !loop_output_two_n && loopback_enable;
   endproperty
   a_loop_two: assert property (p_loop_two) else $error("loop two"); // RULE21

   property p_match_gate;
      !enh_on && !match_flag_reg && char_match_evt |=> !match_flag_reg;
   endproperty
   a_match_gate: assert property (p_match_gate)
      else $error("match flag set"); // RULE2

   property p_table_a;
      tbl == UCS_TBL_A && rx_code_reg == 2'h3 |-> rx_trig == 8'h0e &&
         tx_trig == 8'h01;
   endproperty
   a_table_a: assert property (p_table_a) else $error("table a"); // RULE10

endmodule : ucs_regs
`default_nettype wire

// File: verification/ucs_line_model.sv
// line-side model: fifo fill counts and serial data
`timescale 1ns/100ps
`default_nettype none
module ucs_line_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] rx_lvl,
   input wire logic [7:0] tx_lvl,
   output logic [7:0] rx_count,
   output logic [7:0] tx_count,
   output logic tx_serial_raw
);
   // fill counts lag the request by one clock, as a fifo would
   always_ff @(posedge clk_sys) begin
      rx_count <= rx_lvl;
      tx_count <= tx_lvl;
   end
   // data flips every cycle so a stuck or late output shows
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_serial_raw <= 1'b1;
      end else begin
         tx_serial_raw <= ~tx_serial_raw;
      end
   end
endmodule : ucs_line_model
`default_nettype wire

// File: verification/ucs_regs_tb.sv
// self-checking bench for the uart control and status registers
`timescale 1ns/100ps
`default_nettype none
module ucs_regs_tb import ucs_pkg::*;;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, sv;
   logic [7:0] paddr, rx_count, tx_count, rx_trigger, tx_trigger, rv, rxl, txl;
   logic [31:0] pwdata, prdata;
   logic line_status_pend, rx_timeout_pend, modem_status_pend;
   logic char_match_evt, cts_rise_evt, rts_rise_evt, modem_status_read;
   logic wakeup_evt, gpio_irq_level, bus_mode_alt_pin, tx_serial_raw;
   logic tx_serial_out, fifo_enable, rx_fifo_clear, tx_fifo_clear;
   logic [3:0] char_bits;
   logic stop_long, parity_enable, parity_even, parity_forced, divisor_select;
   logic dtr_n, rts_n, gpio_modem_select, loopback_enable;
   logic loop_output_one_n, loop_output_two_n, irq_out, irq_oe;
   int error_cnt, num_checks;
   // rows: table select, fifo setup byte, rx level, tx level
   logic [31:0] rows [12] = '{
      32'h00010101, 32'h00410401, 32'h00810801, 32'h00c10e01,
      32'h10010810, 32'h10511008, 32'h10a11818, 32'h10f11c1e,
      32'h20010808, 32'h20511010, 32'h20a13820, 32'h20f13c38};

   ucs_regs #(.CNT_W(8)) ucs_regs_inst (
      .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .line_status_pend, .rx_timeout_pend,
      .modem_status_pend, .rx_count, .tx_count, .char_match_evt,
      .cts_rise_evt, .rts_rise_evt, .modem_status_read, .wakeup_evt,
      .gpio_irq_level, .bus_mode_alt_pin, .tx_serial_raw, .tx_serial_out,
      .fifo_enable, .rx_fifo_clear, .tx_fifo_clear, .rx_trigger,
      .tx_trigger, .char_bits, .stop_long, .parity_enable, .parity_even,
      .parity_forced, .divisor_select, .dtr_n, .rts_n, .gpio_modem_select,
      .loopback_enable, .loop_output_one_n, .loop_output_two_n, .irq_out,
      .irq_oe);
   ucs_line_model ucs_line_model_inst (.clk_sys, .rst, .rx_lvl(rxl),
      .tx_lvl(txl), .rx_count, .tx_count, .tx_serial_raw);

   // ----------------------------------------------------------------
   // bus master and comparison helpers
   // ----------------------------------------------------------------
   // request held until pready seen; ends off-edge so outputs settle
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rv = prdata[7:0];
      sv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk_sys);
   endtask : apb
   task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask : chk
   task automatic isr_is(input logic [7:0] e);
      apb(UCS_OFF_ISR, 1'b0, 8'h00);
      chk("status", e, rv);
   endtask : isr_is
   task automatic tally_and_finish;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #(5000 * 50);
      error_cnt++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      error_cnt = 0;
      num_checks = 0;
      rst = 1'b1;
      {psel, penable, pwrite, line_status_pend, rx_timeout_pend} = '0;
      {modem_status_pend, char_match_evt, cts_rise_evt, rts_rise_evt} = '0;
      {modem_status_read, wakeup_evt, gpio_irq_level, bus_mode_alt_pin} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rxl = 8'h00;
      txl = 8'hc8; // tx fifo well above every trigger
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      isr_is(8'h01);
      chk("lines", 8'h03, {6'h0, dtr_n, rts_n});
      chk("bits", 8'h05, {4'h0, char_bits});
      apb(UCS_OFF_EFE, 1'b1, 8'h10);
      for (int i = 0; i < 12; i++) begin
         apb(UCS_OFF_FCTL, 1'b1, rows[i][31:24]);
         apb(UCS_OFF_FCR, 1'b1, rows[i][23:16]);
         chk("rx_trig", rows[i][15:8], rx_trigger);
         chk("tx_trig", rows[i][7:0], tx_trigger);
      end
      // programmable levels, routed by feature control bit 7
      apb(UCS_OFF_FCTL, 1'b1, 8'h30);
      apb(UCS_OFF_TRG, 1'b1, 8'h20);
      apb(UCS_OFF_FCTL, 1'b1, 8'hb0);
      apb(UCS_OFF_TRG, 1'b1, 8'h28);
      chk("prog", 8'h28, tx_trigger);
      chk("prog", 8'h20, rx_trigger);
      apb(UCS_OFF_FCTL, 1'b1, 8'h20);
      apb(UCS_OFF_FCR, 1'b1, 8'hc0); // fields dropped without enable
      chk("fifo_en", 8'h00, {7'h0, fifo_enable});
      chk("rx_trig", 8'h3c, rx_trigger);
      isr_is(8'h01);
      apb(UCS_OFF_FCR, 1'b1, 8'hf7);
      chk("clear", 8'h03, {6'h0, rx_fifo_clear, tx_fifo_clear});
      @(negedge clk_sys);
      chk("clear", 8'h00, {6'h0, rx_fifo_clear,
         tx_fifo_clear});
      apb(UCS_OFF_GIE, 1'b1, 8'h01);
      gpio_irq_level <= 1'b1;
      isr_is(8'h81);
      gpio_irq_level <= 1'b0;
      rxl <= 8'h3c;
      line_status_pend <= 1'b1;
      rx_timeout_pend <= 1'b1;
      isr_is(8'hc6);
      chk("irq", 8'h01, {7'h0, irq_out});
      line_status_pend <= 1'b0;
      isr_is(8'hcc);
      rx_timeout_pend <= 1'b0;
      isr_is(8'hc4);
      rxl <= 8'h3b;
      txl <= 8'h37;
      isr_is(8'hc2);
      txl <= 8'hc8;
      @(posedge clk_sys);
      char_match_evt <= 1'b1;
      @(posedge clk_sys);
      char_match_evt <= 1'b0;
      isr_is(8'hd0);
      isr_is(8'hc1);
      cts_rise_evt <= 1'b1;
      @(posedge clk_sys);
      cts_rise_evt <= 1'b0;
      isr_is(8'he0);
      modem_status_read <= 1'b1;
      @(posedge clk_sys);
      modem_status_read <= 1'b0;
      isr_is(8'hc1);
      apb(UCS_OFF_FCR, 1'b1, 8'hf9);
      wakeup_evt <= 1'b1;
      @(posedge clk_sys);
      wakeup_evt <= 1'b0;
      isr_is(8'hc0);
      isr_is(8'hc1);
      for (int i = 0; i < 4; i++) begin
         apb(UCS_OFF_LCR, 1'b1, 8'h04 | i[7:0]);
         chk("bits", 8'h05 + i[7:0], {4'h0, char_bits});
         chk("stop", 8'h01, {7'h0, stop_long});
      end
      apb(UCS_OFF_LCR, 1'b1, 8'h38);
      chk("parity", 8'h07, {5'h0, parity_enable, parity_even,
         parity_forced});
      apb(UCS_OFF_LCR, 1'b1, 8'h08);
      chk("parity", 8'h04, {5'h0, parity_enable, parity_even,
         parity_forced});
      // serial output is registered, so look one clock later
      apb(UCS_OFF_LCR, 1'b1, 8'hc0);
      @(negedge clk_sys);
      chk("brk_div", 8'h01, {6'h0, tx_serial_out,
         divisor_select});
      apb(UCS_OFF_LCR, 1'b1, 8'h00);
      @(negedge clk_sys);
      chk("tx", {7'h0, ~tx_serial_raw}, {7'h0, tx_serial_out});
      apb(UCS_OFF_MCR, 1'b1, 8'h0b);
      chk("modem", 8'h04, {3'h0, dtr_n, rts_n, irq_oe, loopback_enable,
         gpio_modem_select});
      apb(UCS_OFF_MCR, 1'b1, 8'h1c);
      chk("modem", 8'h7c, {1'b0, dtr_n, rts_n, irq_oe, loopback_enable,
         gpio_modem_select, loop_output_one_n,
         loop_output_two_n});
      apb(8'h40, 1'b0, 8'h00);
      chk("unmapped", 8'h01, {7'h0, sv});
      @(posedge clk_sys);
      rxl <= 8'h00;
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      // enhanced mode is off again, so a match must not flag
      {char_match_evt, bus_mode_alt_pin} <= 2'b11;
      apb(UCS_OFF_LCR, 1'b0, 8'h00);
      chk("line", UCS_LCR_RST, rv);
      isr_is(8'h01);
      chk("oe", 8'h01, {7'h0, irq_oe});
      tally_and_finish();
   end
endmodule : ucs_regs_tb
`default_nettype wire
